// *** verilog/pmc_consts.svh ***
// Offsets, field positions, reset values and timing figures of the measurement block
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH
// Register offsets (word index on the register port)
`define PMC_OFS_SETUP    8'h01
`define PMC_OFS_BUS      8'h05
`define PMC_OFS_TEMP     8'h06
`define PMC_OFS_CUR      8'h07
`define PMC_OFS_PWR      8'h08
// Setup register reset value and field positions
`define PMC_SETUP_RST    16'hfb68
`define PMC_MODE_HI      15
`define PMC_MODE_LO      12
`define PMC_BCT_HI       11
`define PMC_BCT_LO       9
`define PMC_SCT_HI       8
`define PMC_SCT_LO       6
`define PMC_TCT_HI       5
`define PMC_TCT_LO       3
`define PMC_AVG_HI       2
`define PMC_AVG_LO       0
// Conversion times in microseconds, code 0 to 7
`define PMC_CT0_US       50
`define PMC_CT1_US       84
`define PMC_CT2_US       150
`define PMC_CT3_US       280
`define PMC_CT4_US       540
`define PMC_CT5_US       1052
`define PMC_CT6_US       2074
`define PMC_CT7_US       4120
// Clock period and derived cycles per microsecond
`define PMC_MCLK_NS      25
`define PMC_CYC_PER_US   (1000 / `PMC_MCLK_NS)
// Power = |I| * V >> 6 gives 480 uW per step
`define PMC_PWR_SHIFT    6
`endif

// *** verilog/pmc_pkg.sv ***
// Types shared by the measurement block
package pmc_pkg;
  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    PMC_ST_IDLE  = 3'b001,
    PMC_ST_CONV  = 3'b010,
    PMC_ST_STORE = 3'b100
  } pmc_state_t;
  // Register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } pmc_req_t;
  // Raw converter samples, read at the end of each conversion
  typedef struct packed {
    logic [15:0] bus;
    logic [11:0] temp;
    logic [15:0] cur;
  } pmc_raw_t;
endpackage : pmc_pkg

// *** verilog/pmc_measure.sv ***
// Conversion sequencer, averaging and result registers of the power monitor
//
// The implementer's own choice: the address-and-strobe port.
`include "pmc_consts.svh"
module pmc_measure #(
  parameter int CYC_PER_US = `PMC_CYC_PER_US  // Cycles per microsecond
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire pmc_pkg::pmc_req_t req,
  input  wire pmc_pkg::pmc_raw_t raw,
  output logic [23:0]           rdata,
  output logic                  conv_busy
);
  // Configuration and sequencer state
  logic [15:0]         setup_ff;     // Converter setup register
  logic                arm_ff;       // Triggered pass pending or running
  pmc_pkg::pmc_state_t state_ff;     // Sequencer state
  pmc_pkg::pmc_state_t nxt_state;
  logic [1:0]          ch_ff;        // 0 bus, 1 temperature, 2 current
  logic [1:0]          nxt_ch;
  logic [19:0]         tmr_ff;       // Cycles left in this conversion
  logic [10:0]         cnt_ff;       // Samples taken on this channel
  logic signed [26:0]  acc_ff;       // Sample sum
  // Results
  logic [15:0]         bus_voltage_result_ff;      // Bus voltage result
  logic [11:0]         temp_ff;      // Die temperature result
  logic [15:0]         cur_ff;       // Current result
  logic [23:0]         pwr_ff;       // Power result
  logic [23:0]         rdata_ff;     // Read data
  logic                busy_ff;      // Sequencer active
  // Decoded fields
  logic [3:0]          mode;
  logic [2:0]          act;          // Active channels {cur, temp, bus}
  logic                cont;         // Continuous mode with channels
  logic                run;          // Sequencer allowed to start
  logic [3:0]          avg_sh;       // log2 of the sample count
  logic [10:0]         navg;         // Samples per result
  logic                setup_wr;     // Write to the setup register
  logic                conv_end;     // Last cycle of one conversion
  logic                pass_end;     // Last channel stored
  logic [19:0]         load_cyc;     // Timer load for the next channel
  logic signed [26:0]  sample_count_sel;          // Averaged sample
  logic signed [26:0]  raw_ext;      // Sample of the current channel
  logic [16:0]         cur_abs;      // Magnitude of the averaged current
  logic [32:0]         pwr_prod;     // Current times bus voltage

  // Conversion code to clock cycles
  function automatic logic [19:0] ct_cyc(input logic [2:0] code);
    logic [31:0] us;
    case (code)
      3'h0:    us = `PMC_CT0_US;
      3'h1:    us = `PMC_CT1_US;
      3'h2:    us = `PMC_CT2_US;
      3'h3:    us = `PMC_CT3_US;
      3'h4:    us = `PMC_CT4_US;
      3'h5:    us = `PMC_CT5_US;
      3'h6:    us = `PMC_CT6_US;
      default: us = `PMC_CT7_US;
    endcase
    return 20'(us * 32'(CYC_PER_US));
  endfunction : ct_cyc

  // Cycles for one conversion on a channel
  function automatic logic [19:0] ch_cyc(input logic [1:0] ch, input logic [15:0] s);
    case (ch)
      2'd0:    ch_cyc = ct_cyc(s[`PMC_BCT_HI:`PMC_BCT_LO]);
      2'd1:    ch_cyc = ct_cyc(s[`PMC_TCT_HI:`PMC_TCT_LO]);
      default: ch_cyc = ct_cyc(s[`PMC_SCT_HI:`PMC_SCT_LO])
                      + ct_cyc(s[`PMC_TCT_HI:`PMC_TCT_LO]);
    endcase
  endfunction : ch_cyc

  // Mode and field decode
  always_comb begin
    mode = setup_ff[`PMC_MODE_HI:`PMC_MODE_LO];
    case (mode)
      4'h1, 4'h9: act = 3'b001;                  // Bus only
      4'h4, 4'hc: act = 3'b010;                  // Temperature only
      4'h5:       act = 3'b011;                  // Temperature and bus
      4'h6, 4'hd: act = 3'b110;                  // Temperature and current
      4'h7, 4'he: act = 3'b111;                  // All three
      default:    act = 3'b000;                  // Shutdown or reserved
    endcase
    cont = mode[3] && (act != 3'b000);
    run = cont || (arm_ff && (act != 3'b000));
    case (setup_ff[`PMC_AVG_HI:`PMC_AVG_LO])
      3'h0:    avg_sh = 4'd0;
      3'h1:    avg_sh = 4'd2;
      3'h2:    avg_sh = 4'd4;
      3'h3:    avg_sh = 4'd6;
      3'h4:    avg_sh = 4'd7;
      3'h5:    avg_sh = 4'd8;
      3'h6:    avg_sh = 4'd9;
      default: avg_sh = 4'd10;
    endcase
    navg = 11'd1 << avg_sh;
  end

  // Strobes and data path
  always_comb begin
    setup_wr = req.wr && (req.addr == `PMC_OFS_SETUP);
    conv_end = (state_ff == pmc_pkg::PMC_ST_CONV) && (tmr_ff == 20'd1);
    pass_end = (state_ff == pmc_pkg::PMC_ST_STORE) && (ch_ff == 2'd2);
    case (ch_ff)
      2'd0:    raw_ext = 27'(signed'(raw.bus));
      2'd1:    raw_ext = 27'(signed'(raw.temp));
      default: raw_ext = 27'(signed'(raw.cur));
    endcase
    sample_count_sel = acc_ff >>> avg_sh;
    cur_abs = sample_count_sel[15] ? 17'(-sample_count_sel[16:0]) : sample_count_sel[16:0];
    pwr_prod = 33'(cur_abs * bus_voltage_result_ff);
  end

  // Next state and channel
  always_comb begin
    nxt_state = state_ff;
    nxt_ch = ch_ff;
    case (state_ff)
      pmc_pkg::PMC_ST_IDLE: begin
        nxt_ch = 2'd0;
        if (run && !setup_wr) begin
          nxt_state = pmc_pkg::PMC_ST_CONV;
        end
      end
      pmc_pkg::PMC_ST_CONV: begin
        // Skip an inactive channel, or finish after the last sample
        if (!act[ch_ff] || (conv_end && (cnt_ff + 11'd1 == navg))) begin
          nxt_state = pmc_pkg::PMC_ST_STORE;
        end
      end
      pmc_pkg::PMC_ST_STORE: begin
        if (pass_end) begin
          nxt_state = pmc_pkg::PMC_ST_IDLE;
        end else begin
          nxt_state = pmc_pkg::PMC_ST_CONV;
          nxt_ch = ch_ff + 2'd1;
        end
      end
      default: nxt_state = pmc_pkg::PMC_ST_IDLE;
    endcase
    // A setup write aborts the pass so new settings take effect cleanly
    if (setup_wr) begin
      nxt_state = pmc_pkg::PMC_ST_IDLE;
    end
    load_cyc = ch_cyc(nxt_ch, setup_ff);
  end

  // Setup register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      setup_ff <= `PMC_SETUP_RST;
    end else if (setup_wr) begin
      setup_ff <= req.wdata;
    end
  end

  // Trigger flag: a new triggered write wins over the pass end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      arm_ff <= 1'b0;
    end else if (setup_wr) begin
      arm_ff <= !req.wdata[`PMC_MODE_HI];
    end else if (pass_end) begin
      arm_ff <= 1'b0;
    end
  end

  // Sequencer state and channel
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= pmc_pkg::PMC_ST_IDLE;
      ch_ff <= 2'd0;
    end else begin
      state_ff <= nxt_state;
      ch_ff <= nxt_ch;
    end
  end

  // Conversion timer, reloaded for every sample
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_ff <= 20'd0;
    end else if (nxt_state == pmc_pkg::PMC_ST_CONV
                 && (state_ff != pmc_pkg::PMC_ST_CONV || conv_end)) begin
      tmr_ff <= load_cyc;
    end else if (state_ff == pmc_pkg::PMC_ST_CONV && tmr_ff != 20'd0) begin
      tmr_ff <= tmr_ff - 20'd1;
    end
  end

  // Sample counter and accumulator
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 11'd0;
      acc_ff <= 27'sd0;
    end else if (state_ff != pmc_pkg::PMC_ST_CONV) begin
      cnt_ff <= 11'd0;
      acc_ff <= 27'sd0;
    end else if (conv_end) begin
      cnt_ff <= cnt_ff + 11'd1;
      acc_ff <= acc_ff + raw_ext;
    end
  end

  // Results, each written whole in one cycle; the port never writes them
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_voltage_result_ff <= 16'h0000;
      temp_ff <= 12'h000;
      cur_ff <= 16'h0000;
      pwr_ff <= 24'h000000;
    end else if (state_ff == pmc_pkg::PMC_ST_STORE && act[ch_ff]) begin
      case (ch_ff)
        2'd0: bus_voltage_result_ff <= sample_count_sel[15] ? 16'h0000 : sample_count_sel[15:0];
        2'd1: temp_ff <= sample_count_sel[11:0];
        default: begin
          cur_ff <= sample_count_sel[15:0];
          pwr_ff <= (|pwr_prod[32:`PMC_PWR_SHIFT + 24]) ? 24'hffffff
                    : pwr_prod[`PMC_PWR_SHIFT + 23:`PMC_PWR_SHIFT];
        end
      endcase
    end
  end

  // Read data, valid the cycle after the read strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 24'h000000;
    end else if (req.rd) begin
      case (req.addr)
        `PMC_OFS_SETUP: rdata_ff <= {8'h00, setup_ff};
        `PMC_OFS_BUS:   rdata_ff <= {8'h00, bus_voltage_result_ff};
        `PMC_OFS_TEMP:  rdata_ff <= {8'h00, temp_ff, 4'h0};
        `PMC_OFS_CUR:   rdata_ff <= {8'h00, cur_ff};
        `PMC_OFS_PWR:   rdata_ff <= pwr_ff;
        default:        rdata_ff <= 24'h000000;
      endcase
    end else begin
      rdata_ff <= 24'h000000;
    end
  end

  // Busy flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != pmc_pkg::PMC_ST_IDLE);
    end
  end

  assign rdata = rdata_ff;
  assign conv_busy = busy_ff;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_last_store;
    pass_end && cont && !setup_wr;
  endsequence
  sequence s_restart;
    (state_ff == pmc_pkg::PMC_ST_IDLE) ##1 (state_ff == pmc_pkg::PMC_ST_CONV);
  endsequence
  sequence s_conv_entry;
    (state_ff == pmc_pkg::PMC_ST_CONV) && ($past(state_ff) != pmc_pkg::PMC_ST_CONV) && !$past(setup_wr);
  endsequence

  a_mode_off:
    assert property ((state_ff == pmc_pkg::PMC_ST_IDLE) && (mode == 4'h0 || mode == 4'h8) && !setup_wr
                     |=> state_ff == pmc_pkg::PMC_ST_IDLE)
      else $error("Shutdown mode started a conversion");
  // A setup write in the idle gap may end the loop on purpose, so only a quiet gap must restart
  a_cont_loop:
    assert property (s_last_store ##1 !setup_wr |-> s_restart)
      else $error("Continuous mode did not restart");
  a_single_stop:
    assert property (pass_end && !mode[3] && !setup_wr |=> !arm_ff ##1 state_ff == pmc_pkg::PMC_ST_IDLE)
      else $error("Triggered pass did not stop");
  a_bus_time:
    assert property (s_conv_entry and (ch_ff == 2'd0)
                     |-> tmr_ff == ct_cyc(setup_ff[`PMC_BCT_HI:`PMC_BCT_LO]))
      else $error("Bus conversion time wrong");
  a_temp_time:
    assert property (s_conv_entry and (ch_ff == 2'd1)
                     |-> tmr_ff == ct_cyc(setup_ff[`PMC_TCT_HI:`PMC_TCT_LO]))
      else $error("Temperature conversion time wrong");
  a_cur_time:
    assert property (s_conv_entry and (ch_ff == 2'd2) |-> tmr_ff == ct_cyc(setup_ff[`PMC_SCT_HI:`PMC_SCT_LO])
                     + ct_cyc(setup_ff[`PMC_TCT_HI:`PMC_TCT_LO]))
      else $error("Current conversion time not the sum");
  a_avg_count:
    assert property ((state_ff == pmc_pkg::PMC_ST_STORE) && act[ch_ff] |-> cnt_ff == navg)
      else $error("Result stored before averaging ended");
  a_ro_ignore:
    assert property (req.wr && (req.addr >= `PMC_OFS_BUS) && (req.addr <= `PMC_OFS_PWR)
                     && (state_ff != pmc_pkg::PMC_ST_STORE) |=> $stable(bus_voltage_result_ff) && $stable(pwr_ff))
      else $error("Result register changed by a write");
  a_bus_nonneg:
    assert property (!bus_voltage_result_ff[15])
      else $error("Bus voltage result negative");
  a_temp_nibble:
    assert property (req.rd && req.addr == `PMC_OFS_TEMP |=> rdata[3:0] == 4'h0 && rdata[23:16] == 8'h00)
      else $error("Temperature low bits not zero");
  a_arm_set:
    assert property (setup_wr && !req.wdata[`PMC_MODE_HI] |=> arm_ff)
      else $error("Triggered mode write did not arm a pass");
  // Each result changes only at the store cycle of its own channel
  a_bus_hold:
    assert property (!((state_ff == pmc_pkg::PMC_ST_STORE) && (ch_ff == 2'd0)) |=> $stable(bus_voltage_result_ff))
      else $error("Bus voltage result changed outside its store");
  a_temp_hold:
    assert property (!((state_ff == pmc_pkg::PMC_ST_STORE) && (ch_ff == 2'd1)) |=> $stable(temp_ff))
      else $error("Temperature result changed outside its store");
  a_cur_hold:
    assert property (!((state_ff == pmc_pkg::PMC_ST_STORE) && (ch_ff == 2'd2))
                     |=> $stable(cur_ff) && $stable(pwr_ff))
      else $error("Current or power result changed outside its store");
  a_chan_order:
    assert property ((state_ff == pmc_pkg::PMC_ST_STORE) && !pass_end && !setup_wr
                     |=> (state_ff == pmc_pkg::PMC_ST_CONV) && (ch_ff == $past(ch_ff) + 2'd1))
      else $error("Channels not visited in order");
  a_skip_fast:
    assert property ((state_ff == pmc_pkg::PMC_ST_CONV) && !act[ch_ff] && !setup_wr
                     |=> state_ff == pmc_pkg::PMC_ST_STORE)
      else $error("Inactive channel was converted");
  a_skip_keep:
    assert property ((state_ff == pmc_pkg::PMC_ST_STORE) && !act[ch_ff]
                     |=> $stable(bus_voltage_result_ff) && $stable(temp_ff) && $stable(cur_ff))
      else $error("Inactive channel changed a result");
endmodule : pmc_measure

// *** dv/tb_top.sv ***
// Self-checking bench for the conversion sequencer and result registers
`include "pmc_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic              mclk        = 1'b0;          // Bench clock, 25 ns period
  logic              rst_n       = 1'b0;          // Asynchronous reset, active low
  pmc_pkg::pmc_req_t req         = '0;            // Register port request
  pmc_pkg::pmc_raw_t raw         = '0;            // Raw converter samples
  logic [23:0]       rdata;                       // Read data
  logic              conv_busy;                   // Sequencer busy level
  logic [31:0]       seed        = 32'h9165e171;  // Random generator state
  logic [23:0]       exp_q[$];                    // Expected read data notes
  logic              rd_seen     = 1'b0;          // A read was taken at the last edge
  int                failures    = 0;             // Mismatch counter
  int                check_count = 0;             // Comparison counter
  int                ct_us[8]    = '{50, 84, 150, 280, 540, 1052, 2074, 4120};  // Conversion times
  int                n_avg[8]    = '{1, 4, 16, 64, 128, 256, 512, 1024};        // Averaging counts

  // One cycle per microsecond keeps the longest pass short
  pmc_measure #(.CYC_PER_US(1)) u_pmc_measure (.mclk(mclk), .rst_n(rst_n), .req(req), .raw(raw),
                                               .rdata(rdata), .conv_busy(conv_busy));

  // Clock generator
  always #12.5 mclk = ~mclk;

  // Pseudo-random sequence
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Expected busy cycles of one pass: active channel N*T+1, skipped channel 2
  function automatic int pass_len(input logic [15:0] s);
    logic [2:0] m;  // Current, temperature, bus active
    int         n;  // Samples per result
    n = n_avg[s[2:0]];
    case (s[15:12])
      4'h1, 4'h9: m = 3'b001;
      4'h4, 4'hc: m = 3'b010;
      4'h5: m = 3'b011;
      4'h6, 4'hd: m = 3'b110;
      4'h7, 4'he: m = 3'b111;
      default: return 0;
    endcase
    return (m[0] ? n * ct_us[s[11:9]] + 1 : 2) + (m[1] ? n * ct_us[s[5:3]] + 1 : 2)
           + (m[2] ? n * (ct_us[s[8:6]] + ct_us[s[5:3]]) + 1 : 2);
  endfunction : pass_len

  // Compares read data
  task automatic cmp24(input logic [23:0] got, input logic [23:0] want);
    check_count++;
    if (got !== want) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : cmp24

  // Compares a cycle count
  task automatic cmp_cnt(input int got, input int want);
    cmp24(got[23:0], want[23:0]);
  endtask : cmp_cnt

  // Monitor: read data stands in the cycle after the read strobe
  always @(posedge mclk) begin
    if (rd_seen && exp_q.size() > 0) begin
      cmp24(rdata, exp_q.pop_front());
    end
    rd_seen <= req.rd;
  end

  // One write cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask : wr

  // One read cycle, expectation noted first
  task automatic rd_chk(input logic [7:0] a, input logic [23:0] want);
    exp_q.push_back(want);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge mclk);
    req.rd <= 1'b0;
  endtask : rd_chk

  // Writes a setup word, counts the first pass, then checks restart or stop
  task automatic run_setup(input logic [15:0] s);
    int n;
    int k;
    n = 0;
    k = 0;
    wr(`PMC_OFS_SETUP, s);
    while (conv_busy !== 1'b1 && k < 8) begin
      @(negedge mclk);
      k++;
    end
    while (conv_busy === 1'b1 && n < 60000) begin
      @(negedge mclk);
      n++;
    end
    if (n == 60000) begin
      failures++;
      final_report();
    end
    cmp_cnt(n, pass_len(s));
    // Continuous codes start again after one idle cycle
    if (n != 0 && s[15]) begin
      @(negedge mclk);
      cmp24({23'h0, conv_busy}, 24'h000001);
      wr(`PMC_OFS_SETUP, 16'h0000);
    end
    repeat (4) @(negedge mclk);
    k = 0;
    repeat (16) begin
      @(negedge mclk);
      if (conv_busy !== 1'b0) k++;
    end
    cmp_cnt(k, 0);
  endtask : run_setup

  // Prints the counts and the verdict, ends the run
  task automatic final_report;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    logic [15:0] vb;  // Bus sample
    logic [11:0] tp;  // Temperature sample
    logic [15:0] cu;  // Current sample
    int          ai;  // Current magnitude
    longint      pr;  // Expected power
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    rd_chk(`PMC_OFS_SETUP, 24'h00fb68);
    // Result registers ignore writes; unmapped place reads zero
    for (int a = 5; a <= 8; a++) begin
      wr(a[7:0], 16'hffff);
      rd_chk(a[7:0], 24'h000000);
    end
    rd_chk(8'h3e, 24'h000000);
    // Every mode code, then each time code and averaging codes 0 to 5
    for (int c = 0; c < 16; c++) begin
      run_setup({c[3:0], 12'h000});
    end
    for (int c = 0; c < 8; c++) begin
      run_setup({4'h1, c[2:0], 9'h000});
      run_setup({4'h6, 3'h0, c[2:0], 6'h00});
      run_setup({4'h4, 6'h00, c[2:0], 3'h0});
      if (c < 6) run_setup({4'h1, 9'h000, c[2:0]});
    end
    // Negative bus average clamps to zero
    seed = lfsr(seed);
    raw <= '{bus: 16'h8000 | seed[15:0], temp: 12'h000, cur: 16'h0000};
    run_setup(16'h1000);
    rd_chk(`PMC_OFS_BUS, 24'h000000);
    // Result holds until the four-sample run ends
    seed = lfsr(seed);
    vb = {1'b0, seed[14:0]};
    raw <= '{bus: vb, temp: 12'h000, cur: 16'h0000};
    wr(`PMC_OFS_SETUP, 16'h1001);
    repeat (120) @(posedge mclk);
    rd_chk(`PMC_OFS_BUS, 24'h000000);
    repeat (150) @(posedge mclk);
    rd_chk(`PMC_OFS_BUS, {8'h00, vb});
    // All three channels with random samples
    seed = lfsr(seed);
    vb = {1'b0, seed[14:0]};
    seed = lfsr(seed);
    tp = seed[11:0];
    seed = lfsr(seed);
    cu = seed[15:0] | 16'h8000;
    raw <= '{bus: vb, temp: tp, cur: cu};
    run_setup(16'h7000);
    ai = $signed(cu);
    if (ai < 0) ai = -ai;
    pr = (longint'(ai) * longint'(vb)) >>> 6;
    if (pr > 64'hffffff) pr = 64'hffffff;
    wr(`PMC_OFS_CUR, 16'h1234);
    rd_chk(`PMC_OFS_BUS, {8'h00, vb});
    rd_chk(`PMC_OFS_TEMP, {8'h00, tp, 4'h0});
    rd_chk(`PMC_OFS_CUR, {8'h00, cu});
    rd_chk(`PMC_OFS_PWR, pr[23:0]);
    repeat (4) @(posedge mclk);
    final_report();
  end
endmodule : tb_top
